// >>> hw/scc_defs.svh
// Register indices, field positions and reset values of the spread clock configuration block.
`ifndef SCC_DEFS_SVH
`define SCC_DEFS_SVH
`define SCC_IDX_LOCK 6'h00
`define SCC_IDX_FIRST_PLL 6'h18
`define SCC_IDX_SECOND_PLL 6'h19
`define SCC_IDX_SPR 6'h1a
`define SCC_IDX_CTL2 6'h1b
`define SCC_IDX_STAT 6'h1f
`define SCC_RST_LOCK 1'b0
`define SCC_RST_FIRST_PLL 8'hf8
`define SCC_RST_SECOND_PLL 8'h18
`define SCC_RST_SPR 8'h00
`define SCC_RST_CTL2 8'h02
`define SCC_SECOND_PLL_MASK 8'h1f
`define SCC_SPR_EN 0
`define SCC_SPR_SYNC 1
`define SCC_SPR_WIDTH 2
`define SCC_SPR_GAIN 4
`define SCC_SPR_FINE 5
`define SCC_SPR_RATE 6
`define SCC_CTL2_MODE 0
`define SCC_CTL2_WRST 5
`define SCC_CTL2_FRST 6
`define SCC_CTL2_LOAD 7
`define SCC_AMP_BASE 12'h200
`define SCC_RESP_OKAY 2'h0
`define SCC_RESP_SLVERR 2'h2
`endif

// >>> hw/scc_pkg.sv
// Types shared by the spread clock configuration block.
package scc_pkg;
  typedef enum logic [2:0] {
    SCC_IDLE = 3'b001,
    SCC_WAIT = 3'b010,
    SCC_RUN = 3'b100
  } scc_state_t;
  typedef enum logic [1:0] {
    SCC_MODE_OUT_MULT = 2'h0,
    SCC_MODE_ALL_MULT = 2'h1,
    SCC_MODE_OFF = 2'h2,
    SCC_MODE_ALL_NOMULT = 2'h3
  } scc_mode_t;
endpackage : scc_pkg

// >>> hw/scc_top.sv
// Spread clock configuration registers, start sequencing and AXI4-Lite slave.
`timescale 1ns/1ps
`include "scc_defs.svh"
module scc_top #(
  parameter int OFS_W = 12
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic line_sync_pulse_i,
  output logic [2:0] pll_range_o,
  output logic [1:0] first_pll_cp_o,
  output logic [2:0] first_pll_filter_o,
  output logic [1:0] second_pll_cp_o,
  output logic [2:0] second_pll_filter_o,
  output scc_pkg::scc_mode_t pll_mode_o,
  output logic fine_step_select_o,
  output logic spread_active_o,
  output logic fifo_reset_o,
  output logic signed [OFS_W-1:0] mod_offset_o
);
  import scc_pkg::*;

  // Register file and bus slave state.
  logic lock, next_lock;
  logic [7:0] first_pll, next_first_pll;
  logic [7:0] second_pll, next_second_pll;
  logic [7:0] spr, next_spr;
  logic [6:0] ctl2, next_ctl2;
  logic aw_have, next_aw_have;
  logic [5:0] aw_idx, next_aw_idx;
  logic w_have, next_w_have;
  logic [7:0] w_byte, next_w_byte;
  logic w_en, next_w_en;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;
  logic load_req, next_load_req;
  logic wr_fire;
  logic wr_ok;
  logic cfg_open;
  logic [5:0] ar_idx;

  // Sequencer state.
  scc_state_t state, next_state;
  logic sync_meta, sync_hold, sync_prev;
  logic sync_edge;
  logic fifo_rst, next_fifo_rst;
  logic enter_run;
  logic run;

  assign s_axi_awready_o = !aw_have && !bvalid;
  assign s_axi_wready_o = !w_have && !bvalid;
  assign s_axi_bvalid_o = bvalid;
  assign s_axi_bresp_o = bresp;
  assign s_axi_arready_o = !rvalid;
  assign s_axi_rvalid_o = rvalid;
  assign s_axi_rdata_o = rdata;
  assign s_axi_rresp_o = rresp;
  assign ar_idx = s_axi_araddr_i[7:2];
  assign wr_fire = aw_have && w_have;
  // Config registers other than the lock accept writes only while unlocked.
  assign cfg_open = !lock;

  always_comb begin
    wr_ok = 1'b1;
    unique case (aw_idx)
      `SCC_IDX_LOCK, `SCC_IDX_FIRST_PLL, `SCC_IDX_SECOND_PLL, `SCC_IDX_SPR, `SCC_IDX_CTL2,
      `SCC_IDX_STAT: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always_comb begin
    next_aw_have = aw_have;
    next_aw_idx = aw_idx;
    next_w_have = w_have;
    next_w_byte = w_byte;
    next_w_en = w_en;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_lock = lock;
    next_first_pll = first_pll;
    next_second_pll = second_pll;
    next_spr = spr;
    next_ctl2 = ctl2;
    next_load_req = 1'b0;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      next_aw_have = 1'b1;
      next_aw_idx = s_axi_awaddr_i[7:2];
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      next_w_have = 1'b1;
      next_w_byte = s_axi_wdata_i[7:0];
      next_w_en = s_axi_wstrb_i[0];
    end
    if (wr_fire) begin
      next_aw_have = 1'b0;
      next_w_have = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wr_ok ? `SCC_RESP_OKAY : `SCC_RESP_SLVERR;
      if (w_en) begin
        if (aw_idx == `SCC_IDX_LOCK) begin
          next_lock = w_byte[0];
        end
        if (cfg_open && aw_idx == `SCC_IDX_FIRST_PLL) begin
          next_first_pll = w_byte;
        end
        if (cfg_open && aw_idx == `SCC_IDX_SECOND_PLL) begin
          next_second_pll = w_byte & `SCC_SECOND_PLL_MASK;
        end
        if (cfg_open && aw_idx == `SCC_IDX_SPR) begin
          next_spr = w_byte;
          // A rising enable reloads the waveform state.
          next_load_req = w_byte[`SCC_SPR_EN] && !spr[`SCC_SPR_EN];
        end
        if (cfg_open && aw_idx == `SCC_IDX_CTL2) begin
          next_ctl2 = w_byte[6:0];
          next_load_req = w_byte[`SCC_CTL2_LOAD];
        end
      end
    end
    if (bvalid && s_axi_bready_i) begin
      next_bvalid = 1'b0;
    end
  end

  always_comb begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      next_rvalid = 1'b1;
      next_rresp = `SCC_RESP_OKAY;
      unique case (ar_idx)
        `SCC_IDX_LOCK: next_rdata = {31'h0, lock};
        `SCC_IDX_FIRST_PLL: next_rdata = {24'h0, first_pll};
        `SCC_IDX_SECOND_PLL: next_rdata = {24'h0, second_pll};
        `SCC_IDX_SPR: next_rdata = {24'h0, spr};
        `SCC_IDX_CTL2: next_rdata = {24'h0, 1'b0, ctl2};
        `SCC_IDX_STAT: next_rdata = {29'h0, state == SCC_RUN, state == SCC_WAIT,
                                     state == SCC_IDLE};
        default: begin
          next_rdata = 32'h0;
          next_rresp = `SCC_RESP_SLVERR;
        end
      endcase
    end else if (rvalid && s_axi_rready_i) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      aw_have <= 1'b0;
      aw_idx <= 6'h0;
      w_have <= 1'b0;
      w_byte <= 8'h0;
      w_en <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `SCC_RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `SCC_RESP_OKAY;
      lock <= `SCC_RST_LOCK;
      first_pll <= `SCC_RST_FIRST_PLL;
      second_pll <= `SCC_RST_SECOND_PLL;
      spr <= `SCC_RST_SPR;
      ctl2 <= 7'(`SCC_RST_CTL2);
      load_req <= 1'b0;
    end else begin
      aw_have <= next_aw_have;
      aw_idx <= next_aw_idx;
      w_have <= next_w_have;
      w_byte <= next_w_byte;
      w_en <= next_w_en;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      lock <= next_lock;
      first_pll <= next_first_pll;
      second_pll <= next_second_pll;
      spr <= next_spr;
      ctl2 <= next_ctl2;
      load_req <= next_load_req;
    end
  end

  // The pulse comes from another clock, so it is synchronised before the edge detector.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      sync_meta <= 1'b0;
      sync_hold <= 1'b0;
      sync_prev <= 1'b0;
    end else begin
      sync_meta <= line_sync_pulse_i;
      sync_hold <= sync_meta;
      sync_prev <= sync_hold;
    end
  end
  assign sync_edge = sync_hold && !sync_prev;

  always_comb begin
    next_state = state;
    unique case (state)
      SCC_IDLE: begin
        if (spr[`SCC_SPR_EN] && spr[`SCC_SPR_SYNC]) begin
          next_state = SCC_WAIT;
        end else if (spr[`SCC_SPR_EN] && lock) begin
          next_state = SCC_RUN;
        end
      end
      SCC_WAIT: begin
        if (!spr[`SCC_SPR_EN]) begin
          next_state = SCC_IDLE;
        end else if (sync_edge) begin
          next_state = SCC_RUN;
        end
      end
      SCC_RUN: begin
        if (!spr[`SCC_SPR_EN]) begin
          next_state = SCC_IDLE;
        end
      end
      default: next_state = SCC_IDLE;
    endcase
  end

  assign enter_run = (state != SCC_RUN) && (next_state == SCC_RUN);
  assign run = state == SCC_RUN;

  always_comb begin
    // The FIFO always restarts with spreading; line-sync resets are optional.
    next_fifo_rst = enter_run || (run && sync_edge && ctl2[`SCC_CTL2_FRST]);
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state <= SCC_IDLE;
      fifo_rst <= 1'b0;
    end else begin
      state <= next_state;
      fifo_rst <= next_fifo_rst;
    end
  end

  scc_wave #(
    .W(OFS_W)
  ) u_wave (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .run_i(run),
    .load_i(load_req),
    .wave_reset_i(run && sync_edge && ctl2[`SCC_CTL2_WRST]),
    .width_i(spr[`SCC_SPR_WIDTH +: 2]),
    .gain_i(spr[`SCC_SPR_GAIN]),
    .rate_i(spr[`SCC_SPR_RATE +: 2]),
    .offset_o(mod_offset_o)
  );

  assign pll_range_o = first_pll[7:5];
  assign first_pll_cp_o = first_pll[4:3];
  assign first_pll_filter_o = first_pll[2:0];
  assign second_pll_cp_o = second_pll[4:3];
  assign second_pll_filter_o = second_pll[2:0];
  assign pll_mode_o = scc_mode_t'(ctl2[1:0]);
  assign fine_step_select_o = spr[`SCC_SPR_FINE];
  assign spread_active_o = run;
  assign fifo_reset_o = fifo_rst;

  property p_lock_blocks;
    @(posedge clk_i) disable iff (!reset_n_i)
      wr_fire && lock && aw_idx == `SCC_IDX_SPR |=> $stable(spr);
  endproperty
  a_lock_blocks: assert property (p_lock_blocks) else $error("locked write landed");

  property p_reset_vals;
    @(posedge clk_i) disable iff (!reset_n_i)
      $rose(reset_n_i) |-> pll_range_o == 3'h7 && first_pll_cp_o == 2'h3
      && first_pll_filter_o == 3'h0 && pll_mode_o == SCC_MODE_OFF;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");

  property p_en_load;
    @(posedge clk_i) disable iff (!reset_n_i) $rose(spr[`SCC_SPR_EN]) |=> mod_offset_o == 0;
  endproperty
  a_en_load: assert property (p_en_load) else $error("enable did not reload");

  property p_imm_start;
    @(posedge clk_i) disable iff (!reset_n_i)
      state == SCC_IDLE && spr[`SCC_SPR_EN] && !spr[`SCC_SPR_SYNC] && lock
      |=> spread_active_o;
  endproperty
  a_imm_start: assert property (p_imm_start) else $error("no immediate start");

  property p_sync_wait;
    @(posedge clk_i) disable iff (!reset_n_i)
      state == SCC_WAIT && !sync_edge |=> !spread_active_o;
  endproperty
  a_sync_wait: assert property (p_sync_wait) else $error("started before line sync");

  property p_sync_go;
    @(posedge clk_i) disable iff (!reset_n_i)
      state == SCC_WAIT && sync_edge && spr[`SCC_SPR_EN] |=> spread_active_o && fifo_reset_o;
  endproperty
  a_sync_go: assert property (p_sync_go) else $error("line sync start missed");

  property p_fifo_sync;
    @(posedge clk_i) disable iff (!reset_n_i)
      run && sync_edge && ctl2[`SCC_CTL2_FRST] |=> fifo_reset_o;
  endproperty
  a_fifo_sync: assert property (p_fifo_sync) else $error("fifo reset missed");

  property p_stop;
    @(posedge clk_i) disable iff (!reset_n_i)
      !spr[`SCC_SPR_EN] |=> !spread_active_o ##1 mod_offset_o == 0;
  endproperty
  a_stop: assert property (p_stop) else $error("spreading not stopped");

  c_imm: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    state == SCC_IDLE ##1 state == SCC_RUN);
  c_sync: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    state == SCC_WAIT ##1 state == SCC_RUN);
  c_locked_wr: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    wr_fire && lock && aw_idx == `SCC_IDX_SPR);
endmodule : scc_top

// >>> hw/scc_wave.sv
// Triangle modulation generator for the spread clock generator.
`timescale 1ns/1ps
`include "scc_defs.svh"
module scc_wave #(
  parameter int W = 12
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic run_i,
  input wire logic load_i,
  input wire logic wave_reset_i,
  input wire logic [1:0] width_i,
  input wire logic gain_i,
  input wire logic [1:0] rate_i,
  output logic signed [W-1:0] offset_o
);
  logic signed [W-1:0] phase;
  logic signed [W-1:0] next_phase;
  logic down;
  logic next_down;
  logic [W-1:0] amp;
  logic signed [W-1:0] step;
  logic signed [W-1:0] sum;

  always_comb begin
    amp = W'(`SCC_AMP_BASE) >> width_i;
    if (gain_i) begin
      amp = amp << 1;
    end
    // The reserved rate code falls back to 1x rather than an unknown rate.
    step = (rate_i == 2'h3) ? W'(1) : W'(1) << rate_i;
    sum = down ? phase - step : phase + step;
    next_phase = phase;
    next_down = down;
    if (!run_i || load_i || wave_reset_i) begin
      next_phase = '0;
      next_down = 1'b0;
    end else if (!down && sum >= $signed(amp)) begin
      next_phase = $signed(amp);
      next_down = 1'b1;
    end else if (down && sum <= -$signed(amp)) begin
      next_phase = -$signed(amp);
      next_down = 1'b0;
    end else begin
      next_phase = sum;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      phase <= '0;
      down <= 1'b0;
    end else begin
      phase <= next_phase;
      down <= next_down;
    end
  end

  assign offset_o = phase;

  property p_amp_bound;
    @(posedge clk_i) disable iff (!reset_n_i)
      (phase <= $signed(amp)) && (phase >= -$signed(amp));
  endproperty
  a_amp_bound: assert property (p_amp_bound) else $error("offset beyond width");

  property p_step_size;
    @(posedge clk_i) disable iff (!reset_n_i)
      run_i && !load_i && !wave_reset_i && $stable(rate_i) && $stable(width_i)
      && $stable(gain_i) ##1 $past(phase) != amp && $past(phase) != -amp
      |-> (phase - $past(phase) == step) || ($past(phase) - phase == step);
  endproperty
  a_step_size: assert property (p_step_size) else $error("modulation step wrong");

  property p_wave_reset;
    @(posedge clk_i) disable iff (!reset_n_i) wave_reset_i |=> phase == 0;
  endproperty
  a_wave_reset: assert property (p_wave_reset) else $error("waveform not reset");
endmodule : scc_wave

// >>> verif/scc_host.sv
// Host controller model: AXI4-Lite master and line-sync source for the spread clock block.
`timescale 1ns/1ps
module scc_host (
  input wire logic clk_i,
  output logic [7:0] aw_o,
  output logic awv_o,
  input wire logic awr_i,
  output logic [31:0] wd_o,
  output logic [3:0] ws_o,
  output logic wv_o,
  input wire logic wr_i,
  output logic br_o,
  input wire logic bv_i,
  input wire logic [1:0] bresp_i,
  output logic [7:0] ar_o,
  output logic arv_o,
  input wire logic arr_i,
  output logic rr_o,
  input wire logic rv_i,
  input wire logic [31:0] rd_i,
  input wire logic [1:0] rresp_i,
  output logic sync_o
);
  initial begin
    aw_o = 8'h00;
    awv_o = 1'b0;
    wd_o = 32'h00000000;
    ws_o = 4'hf;
    wv_o = 1'b0;
    br_o = 1'b0;
    ar_o = 8'h00;
    arv_o = 1'b0;
    rr_o = 1'b0;
    sync_o = 1'b0;
  end

  task automatic hang();
    scc_top_tb_top.mismatches++;
    scc_top_tb_top.finish_test();
  endtask : hang

  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] resp);
    logic done;
    done = 1'b0;
    resp = 2'h3;
    @(posedge clk_i);
    aw_o <= a;
    awv_o <= 1'b1;
    wd_o <= {24'h000000, d};
    wv_o <= 1'b1;
    br_o <= 1'b1;
    for (int n = 0; n < 64 && !done; n++) begin
      @(posedge clk_i);
      if (awv_o && awr_i) awv_o <= 1'b0;
      if (wv_o && wr_i) wv_o <= 1'b0;
      if (bv_i) begin
        resp = bresp_i;
        br_o <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) hang();
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic done;
    done = 1'b0;
    d = 32'hffffffff;
    resp = 2'h3;
    @(posedge clk_i);
    ar_o <= a;
    arv_o <= 1'b1;
    rr_o <= 1'b1;
    for (int n = 0; n < 64 && !done; n++) begin
      @(posedge clk_i);
      if (arv_o && arr_i) arv_o <= 1'b0;
      if (rv_i) begin
        d = rd_i;
        resp = rresp_i;
        rr_o <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) hang();
  endtask : rd

  // Spreading is stopped before its fields move, so the waveform never runs on half a setting.
  task automatic change_spread(input logic [7:0] v);
    logic [1:0] r;
    logic [31:0] cur;
    wr(8'h00, 8'h00, r);
    rd(8'h68, cur, r);
    wr(8'h68, cur[7:0] & 8'hfe, r);
    wr(8'h68, v & 8'hfe, r);
    wr(8'h68, v, r);
    wr(8'h00, 8'h01, r);
  endtask : change_spread

  task automatic prep_second_pll();
    logic [1:0] r;
    wr(8'h64, 8'h07, r);
  endtask : prep_second_pll

  // Held three cycles so the two-stage synchroniser cannot miss it.
  task automatic line_sync();
    @(posedge clk_i);
    sync_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    sync_o <= 1'b0;
  endtask : line_sync
endmodule : scc_host

// >>> verif/scc_top_tb_top.sv
// Testbench for the spread clock configuration block.
`timescale 1ns/1ps
`include "scc_defs.svh"
module scc_top_tb_top;
  import scc_pkg::*;
  logic clk_i, reset_n_i, line_sync_pulse_i;
  logic [7:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, d;
  logic [3:0] s_axi_wstrb_i;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, first_pll_cp_o, second_pll_cp_o, r;
  logic s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
  logic s_axi_rvalid_o, s_axi_rready_i, fine_step_select_o, spread_active_o, fifo_reset_o;
  logic [2:0] pll_range_o, first_pll_filter_o, second_pll_filter_o;
  scc_mode_t pll_mode_o;
  logic signed [11:0] mod_offset_o, peak;
  int mismatches, cmp_count, n, fifo_seen;
  logic [7:0] addrs [3] = '{8'h60, 8'h64, 8'h68};
  logic [31:0] rstv [3] = '{32'hf8, 32'h18, 32'h00};

  scc_top #(.OFS_W(12)) scc_top_inst (.clk_i, .reset_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
    .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
    .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
    .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
    .line_sync_pulse_i, .pll_range_o, .first_pll_cp_o, .first_pll_filter_o, .second_pll_cp_o,
    .second_pll_filter_o, .pll_mode_o, .fine_step_select_o, .spread_active_o, .fifo_reset_o,
    .mod_offset_o);

  scc_host scc_host_inst (.clk_i(clk_i), .aw_o(s_axi_awaddr_i), .awv_o(s_axi_awvalid_i),
    .awr_i(s_axi_awready_o), .wd_o(s_axi_wdata_i), .ws_o(s_axi_wstrb_i),
    .wv_o(s_axi_wvalid_i), .wr_i(s_axi_wready_o), .br_o(s_axi_bready_i),
    .bv_i(s_axi_bvalid_o), .bresp_i(s_axi_bresp_o), .ar_o(s_axi_araddr_i),
    .arv_o(s_axi_arvalid_i), .arr_i(s_axi_arready_o), .rr_o(s_axi_rready_i),
    .rv_i(s_axi_rvalid_o), .rd_i(s_axi_rdata_o), .rresp_i(s_axi_rresp_o),
    .sync_o(line_sync_pulse_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (mod_offset_o > peak) peak <= mod_offset_o;
    if (fifo_reset_o === 1'b1) fifo_seen <= fifo_seen + 1;
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask : cyc

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wait_active();
    for (int k = 0; k < 20 && spread_active_o !== 1'b1; k++) cyc(1);
    if (spread_active_o !== 1'b1) begin
      mismatches++;
      finish_test();
    end
  endtask : wait_active

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    reset_n_i = 1'b0;
    mismatches = 0;
    cmp_count = 0;
    fifo_seen = 0;
    peak = 12'sh000;
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    cyc(1);
    check(pll_range_o, 32'h7, "range");
    check(first_pll_cp_o, 32'h3, "cp1");
    check(first_pll_filter_o, 32'h0, "filter1");
    check(pll_mode_o, SCC_MODE_OFF, "mode");
    for (n = 0; n < 3; n++) begin
      scc_host_inst.rd(addrs[n], d, r);
      check(d, rstv[n], "reset value");
    end
    scc_host_inst.rd(8'h40, d, r);
    check(r, `SCC_RESP_SLVERR, "unmapped read resp");
    check(d, 32'h0, "unmapped read data");
    scc_host_inst.wr(8'h44, 8'h5a, r);
    check(r, `SCC_RESP_SLVERR, "unmapped write resp");
    $display("test reset and map done");

    scc_host_inst.wr(8'h00, 8'h00, r);
    for (n = 0; n < 4; n++) begin
      scc_host_inst.wr(8'h6c, n[7:0], r);
      cyc(1);
      check(pll_mode_o, n[1:0], "mode");
    end
    scc_host_inst.wr(8'h6c, 8'h62, r);
    scc_host_inst.prep_second_pll();
    scc_host_inst.wr(8'h68, 8'hbc, r);
    cyc(1);
    check(second_pll_cp_o, 32'h0, "cp2");
    check(second_pll_filter_o, 32'h7, "filter2");
    check(fine_step_select_o, 1'b1, "fine step");
    scc_host_inst.wr(8'h68, 8'hbd, r);
    cyc(5);
    check(spread_active_o, 1'b0, "active unlocked");
    fifo_seen = 0;
    scc_host_inst.wr(8'h00, 8'h01, r);
    wait_active();
    check(spread_active_o, 1'b1, "active locked");
    cyc(3);
    check(fifo_seen, 32'h1, "start fifo reset");
    peak = 12'sh000;
    cyc(300);
    check(peak, 32'h80, "peak offset");
    scc_host_inst.wr(8'h60, 8'h00, r);
    scc_host_inst.rd(8'h60, d, r);
    check(d, 32'hf8, "locked write");
    $display("test immediate start done");

    scc_host_inst.change_spread(8'h03);
    cyc(10);
    check(spread_active_o, 1'b0, "waiting for sync");
    scc_host_inst.rd(8'h7c, d, r);
    check(d, 32'h2, "status waiting");
    scc_host_inst.line_sync();
    wait_active();
    check(spread_active_o, 1'b1, "started on sync");
    scc_host_inst.rd(8'h7c, d, r);
    check(d, 32'h4, "status running");
    cyc(5);
    fifo_seen = 0;
    scc_host_inst.line_sync();
    cyc(10);
    check(fifo_seen, 32'h1, "sync fifo reset");
    check(spread_active_o, 1'b1, "still running");
    // The self-clearing reload command restarts the waveform and is never stored.
    scc_host_inst.wr(8'h00, 8'h00, r);
    scc_host_inst.wr(8'h6c, 8'he2, r);
    #1;
    check(mod_offset_o, 32'h0, "reload offset");
    scc_host_inst.rd(8'h6c, d, r);
    check(d, 32'h62, "reload not stored");
    $display("test line sync start done");
    finish_test();
  end
endmodule : scc_top_tb_top
